// ==== design/rmp_register_map_protection.sv ====
// Purpose: page decode, access locks and crc protection of the register map
// Assumes: register file answers scan reads combinationally on clk_sys_i
// Notes: access result appears one cycle after acc_valid_i
// Summary of operation
// - primary bus pages 0-3 via low two bits
// - page 4 at separate secondary identifier
// - serial page field selects page directly
// - continuous crc-16 over pages 1-3
// - mismatch sets error flag, requests shutdown
// - crc-16 uses the given generator polynomial
// - preset ones, msb first, inverted result
// - page 1 blocked in functional mode
// - reserved ones stay in checksum, cause mismatch
// - dynamic crc-8 updated on page 1/4 writes to addresses 0x00-0x0f
// - dynamic checksums verified round robin
// - dynamic crc-8 uses polynomial 0xa6
// - monitor config writes rejected while running
// - key 0x9b unlocks, other values lock
// - lock spares monitor config and interrupts
// - lock status readable, one means locked
// - every start-up leaves user registers unlocked
// - switching rate bits locked by nvm setting
module rmp_register_map_protection (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic acc_valid_i,
  input wire logic acc_write_i,
  input wire logic acc_is_serial_i,
  input wire logic acc_on_secondary_i,
  input wire logic [6:0] acc_dev_addr_i,
  input wire logic [2:0] acc_page_field_i,
  input wire logic [7:0] acc_reg_addr_i,
  input wire logic [7:0] acc_wdata_i,
  input wire logic acc_is_wd_cfg_i,
  input wire logic acc_is_esm_cfg_i,
  input wire logic acc_is_rate_sel_i,
  input wire logic [6:0] primary_bus_base_identifier_i,
  input wire logic [6:0] secondary_bus_identifier_i,
  input wire logic secondary_bus_used_i,
  input wire logic functional_mode_i,
  input wire logic supervision_timer_running_i,
  input wire logic error_signal_monitor_running_i,
  input wire logic rate_choice_nvm_lock_i,
  input wire logic startup_i,
  input wire logic nvm_loaded_i,
  input wire logic [15:0] nvm_crc16_expected_i,
  input wire logic [7:0] static_scan_data_i,
  input wire logic [7:0] dyn_scan_data_i,
  input wire logic crc_flag_clear_i,
  output logic acc_done_o,
  output logic acc_hit_o,
  output logic acc_granted_o,
  output logic [2:0] acc_page_o,
  output logic reg_wr_en_o,
  output logic [2:0] reg_wr_page_o,
  output logic [7:0] reg_wr_addr_o,
  output logic [7:0] reg_wr_data_o,
  output logic [2:0] static_scan_page_o,
  output logic [7:0] static_scan_addr_o,
  output logic [2:0] dyn_scan_page_o,
  output logic [7:0] dyn_scan_addr_o,
  output logic user_lock_status_o,
  output logic reg_crc_error_flag_o,
  output logic shutdown_request_o
);
  // ==========================================
  // crc step functions, one byte msb first
  function automatic logic [15:0] rmp_crc16_byte(input logic [15:0] crc, input logic [7:0] d);
    logic [15:0] c;
    c = crc;
    for (int i = 7; i >= 0; i--) begin
      c = (c[15] ^ d[i]) ? ({c[14:0], 1'b0} ^ rmp_pkg::CRC16_POLY) : {c[14:0], 1'b0};
    end
    return c;
  endfunction : rmp_crc16_byte

  function automatic logic [7:0] rmp_crc8_byte(input logic [7:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ rmp_pkg::CRC8_POLY) : {c[6:0], 1'b0};
    end
    return c;
  endfunction : rmp_crc8_byte

  // ==========================================
  // page decode
  logic base_match_w;
  logic sec_match_w;
  logic spi_ok_w;
  logic hit_w;
  logic [2:0] page_w;
  // pages 0-3 share the base id with the low two bits replaced
  assign base_match_w = !acc_on_secondary_i && (acc_dev_addr_i[6:2] ==
                        primary_bus_base_identifier_i[6:2]);
  // page 4 on the secondary bus, or on the primary bus when alone
  assign sec_match_w = (acc_dev_addr_i == secondary_bus_identifier_i) &&
                       (acc_on_secondary_i == secondary_bus_used_i);
  assign spi_ok_w = acc_page_field_i <= rmp_pkg::SPI_PAGE_MAX;
  assign hit_w = acc_is_serial_i ? spi_ok_w : (base_match_w || sec_match_w);
  assign page_w = acc_is_serial_i ? acc_page_field_i :
                  sec_match_w ? rmp_pkg::PAGE_SUPERVISION_TIMER : {1'b0, acc_dev_addr_i[1:0]};

  // ==========================================
  // access permission
  logic lock_reg;
  logic lock_next;
  logic is_key_w;
  logic exempt_w;
  logic deny_w;
  logic grant_w;
  assign is_key_w = (page_w == rmp_pkg::PAGE_USER) && (acc_reg_addr_i == rmp_pkg::LOCK_KEY_ADDR);
  // interrupt flags, monitor config and the key stay writable
  assign exempt_w = is_key_w || acc_is_wd_cfg_i || acc_is_esm_cfg_i ||
                    ((acc_reg_addr_i >= rmp_pkg::INT_ADDR_FIRST) &&
                     (acc_reg_addr_i <= rmp_pkg::INT_ADDR_LAST));
  assign deny_w = !hit_w ||
                  ((page_w == rmp_pkg::PAGE_NVM) && functional_mode_i) ||
                  (acc_write_i && (
                    ((page_w == rmp_pkg::PAGE_USER) && lock_reg && !exempt_w) ||
                    (acc_is_wd_cfg_i && supervision_timer_running_i) ||
                    (acc_is_esm_cfg_i && error_signal_monitor_running_i) ||
                    (acc_is_rate_sel_i && rate_choice_nvm_lock_i)));
  assign grant_w = acc_valid_i && !deny_w;

  // key write decides the lock, start-up always unlocks
  assign lock_next = startup_i ? rmp_pkg::LOCK_RESET :
                     (grant_w && acc_write_i && is_key_w) ?
                     (acc_wdata_i != rmp_pkg::LOCK_KEY_VALUE) : lock_reg;
  assign user_lock_status_o = lock_reg;

  // lock state
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      lock_reg <= rmp_pkg::LOCK_RESET;
    end else begin
      lock_reg <= lock_next;
    end
  end

  // registered access answer and write strobe
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      acc_done_o <= 1'b0;
      acc_hit_o <= 1'b0;
      acc_granted_o <= 1'b0;
      acc_page_o <= 3'h0;
      reg_wr_en_o <= 1'b0;
      reg_wr_page_o <= 3'h0;
      reg_wr_addr_o <= 8'h00;
      reg_wr_data_o <= 8'h00;
    end else begin
      acc_done_o <= acc_valid_i;
      acc_hit_o <= acc_valid_i && hit_w;
      acc_granted_o <= grant_w;
      acc_page_o <= acc_valid_i ? page_w : acc_page_o;
      reg_wr_en_o <= grant_w && acc_write_i;
      reg_wr_page_o <= grant_w ? page_w : reg_wr_page_o;
      reg_wr_addr_o <= grant_w ? acc_reg_addr_i : reg_wr_addr_o;
      reg_wr_data_o <= grant_w ? acc_wdata_i : reg_wr_data_o;
    end
  end

  // ==========================================
  // static crc-16 scan over pages 1 to 3
  rmp_pkg::rmp_scan_state_type st_reg;
  rmp_pkg::rmp_scan_state_type st_next;
  logic [9:0] st_cnt_reg;
  logic [15:0] crc16_reg;
  logic [15:0] crc16_step_w;
  logic static_mm_reg;
  logic static_mm_w;
  // raw bytes go in, so a reserved one breaks the match
  assign crc16_step_w = rmp_crc16_byte(crc16_reg, static_scan_data_i);
  assign static_mm_w = (st_reg == rmp_pkg::ST_CHECK) &&
                       ((~crc16_reg) != nvm_crc16_expected_i);
  assign static_scan_page_o = {1'b0, st_cnt_reg[9:8]} + 3'h1;
  assign static_scan_addr_o = st_cnt_reg[7:0];

  // scan sequencer
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      rmp_pkg::ST_INIT: begin
        st_next = nvm_loaded_i ? rmp_pkg::ST_RUN : rmp_pkg::ST_INIT;
      end
      rmp_pkg::ST_RUN: begin
        st_next = (st_cnt_reg == rmp_pkg::STATIC_LAST) ? rmp_pkg::ST_CHECK : rmp_pkg::ST_RUN;
      end
      rmp_pkg::ST_CHECK: begin
        st_next = rmp_pkg::ST_INIT;
      end
      default: begin
        st_next = rmp_pkg::ST_INIT;
      end
    endcase
  end

  // scan registers
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      st_reg <= rmp_pkg::ST_INIT;
      st_cnt_reg <= rmp_pkg::STATIC_FIRST;
      crc16_reg <= rmp_pkg::CRC16_INIT;
      static_mm_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      st_cnt_reg <= (st_reg == rmp_pkg::ST_RUN) ? st_cnt_reg + 10'h001 : rmp_pkg::STATIC_FIRST;
      crc16_reg <= (st_reg == rmp_pkg::ST_RUN) ? crc16_step_w : rmp_pkg::CRC16_INIT;
      static_mm_reg <= static_mm_w;
    end
  end

  // run length counted apart from the scan address, for the length check
  logic [9:0] run_len_reg;
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      run_len_reg <= 10'h000;
    end else begin
      run_len_reg <= (st_reg == rmp_pkg::ST_RUN) ? run_len_reg + 10'h001 : 10'h000;
    end
  end

  // ==========================================
  // dynamic crc-8 store and round-robin check
  logic [7:0] dyn_crc_mem [0:rmp_pkg::DYN_WORDS-1];
  logic [rmp_pkg::DYN_WORDS-1:0] dyn_valid_reg;
  logic [4:0] dyn_idx_reg;
  logic [4:0] dyn_wr_idx_w;
  logic dyn_wr_w;
  logic dyn_mm_reg;
  logic dyn_mm_w;
  assign dyn_wr_idx_w = {reg_wr_page_o == rmp_pkg::PAGE_SUPERVISION_TIMER, reg_wr_addr_o[3:0]};
  assign dyn_wr_w = reg_wr_en_o && (reg_wr_addr_o[7:4] == 4'h0) &&
                    ((reg_wr_page_o == rmp_pkg::PAGE_NVM) ||
                     (reg_wr_page_o == rmp_pkg::PAGE_SUPERVISION_TIMER));
  assign dyn_scan_page_o = dyn_idx_reg[4] ? rmp_pkg::PAGE_SUPERVISION_TIMER : rmp_pkg::PAGE_NVM;
  assign dyn_scan_addr_o = {4'h0, dyn_idx_reg[3:0]};
  assign dyn_mm_w = dyn_valid_reg[dyn_idx_reg] &&
                    (rmp_crc8_byte(dyn_scan_data_i) != dyn_crc_mem[dyn_idx_reg]);

  // checksum memory follows the register file write edge
  always_ff @(posedge clk_sys_i) begin
    if (dyn_wr_w) begin
      dyn_crc_mem[dyn_wr_idx_w] <= rmp_crc8_byte(reg_wr_data_o);
    end
  end

  // round-robin pointer and entry validity
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      dyn_valid_reg <= '0;
      dyn_idx_reg <= 5'h00;
      dyn_mm_reg <= 1'b0;
    end else begin
      dyn_idx_reg <= dyn_idx_reg + 5'h01;
      dyn_mm_reg <= dyn_mm_w;
      if (dyn_wr_w) begin
        dyn_valid_reg[dyn_wr_idx_w] <= 1'b1;
      end
    end
  end

  // ==========================================
  // error flag and shutdown request, set beats clear
  logic err_set_w;
  assign err_set_w = static_mm_reg || dyn_mm_reg;
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      reg_crc_error_flag_o <= 1'b0;
      shutdown_request_o <= 1'b0;
    end else begin
      reg_crc_error_flag_o <= err_set_w || (reg_crc_error_flag_o && !crc_flag_clear_i);
      shutdown_request_o <= err_set_w;
    end
  end

  // ==========================================
  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  chk_key_unlock: assert property (grant_w && acc_write_i && is_key_w && !startup_i &&
    acc_wdata_i == 8'h9b |=> !user_lock_status_o) else $error("key did not unlock");
  chk_key_relock: assert property (grant_w && acc_write_i && is_key_w && !startup_i &&
    acc_wdata_i != 8'h9b |=> user_lock_status_o) else $error("bad key did not lock");
  chk_startup_unlock: assert property (startup_i |=> !user_lock_status_o)
    else $error("start-up left lock set");
  chk_page1_block: assert property (acc_valid_i && hit_w && page_w == 3'h1 &&
    functional_mode_i |=> acc_done_o && !acc_granted_o) else $error("page 1 not blocked");
  chk_locked_user_write: assert property (acc_valid_i && acc_write_i &&
    user_lock_status_o && hit_w && page_w == 3'h0 && !exempt_w |=> !acc_granted_o && !reg_wr_en_o)
    else $error("locked write passed");
  chk_primary_page: assert property (acc_valid_i && !acc_is_serial_i && base_match_w &&
    !sec_match_w |=> acc_hit_o && acc_page_o == {1'b0, $past(acc_dev_addr_i[1:0])})
    else $error("primary page wrong");
  chk_secondary_page: assert property (acc_valid_i && !acc_is_serial_i && sec_match_w
    |=> acc_hit_o && acc_page_o == 3'h4) else $error("page 4 not decoded");
  chk_serial_page: assert property (acc_valid_i && acc_is_serial_i &&
    acc_page_field_i <= 3'h3 |=> acc_page_o == $past(acc_page_field_i))
    else $error("serial page wrong");
  chk_monitor_cfg: assert property (acc_valid_i && acc_write_i && acc_is_wd_cfg_i &&
    supervision_timer_running_i |=> !reg_wr_en_o) else $error("running monitor changed");
  chk_rate_lock: assert property (acc_valid_i && acc_write_i && acc_is_rate_sel_i &&
    rate_choice_nvm_lock_i |=> !acc_granted_o) else $error("rate choice not locked");
  chk_static_error: assert property (static_mm_w |-> ##2 reg_crc_error_flag_o &&
    shutdown_request_o) else $error("static mismatch not flagged");
  chk_dyn_error: assert property (dyn_mm_w |=> ##1 reg_crc_error_flag_o &&
    shutdown_request_o) else $error("dynamic mismatch not flagged");
  chk_scan_length: assert property (st_reg == rmp_pkg::ST_CHECK |->
    run_len_reg == rmp_pkg::STATIC_LAST + 10'h001) else $error("scan length wrong");

  cov_unlock_then_write: cover property (!user_lock_status_o ##1 reg_wr_en_o);
  cov_static_mismatch: cover property (static_mm_w);
  cov_dyn_mismatch: cover property (dyn_mm_w);
  cov_page4_access: cover property (acc_granted_o && acc_page_o == 3'h4);
endmodule : rmp_register_map_protection

// ==== design/rmp_pkg.sv ====
// Purpose: constants for the register map protection block
// Assumes: 8-bit registers, 256 registers per page
// Notes: crc polynomials are in normal (msb-first) form
package rmp_pkg;
  // ==========================================
  // pages and page selection
  localparam logic [2:0] PAGE_USER = 3'h0;
  localparam logic [2:0] PAGE_NVM = 3'h1;
  localparam logic [2:0] PAGE_SUPERVISION_TIMER = 3'h4;
  localparam logic [2:0] SPI_PAGE_MAX = 3'h4;
  localparam int PAGE_FIELD_LSB = 2;
  // ==========================================
  // user lock
  localparam logic [7:0] LOCK_KEY_ADDR = 8'ha1;
  localparam logic [7:0] LOCK_KEY_VALUE = 8'h9b;
  localparam logic [7:0] INT_ADDR_FIRST = 8'h5a;
  localparam logic [7:0] INT_ADDR_LAST = 8'h6c;
  localparam logic LOCK_RESET = 1'b0;
  // ==========================================
  // static crc-16
  localparam logic [15:0] CRC16_POLY = 16'h755b;
  localparam logic [15:0] CRC16_INIT = 16'hffff;
  localparam logic [9:0] STATIC_LAST = 10'h2ff;
  localparam logic [9:0] STATIC_FIRST = 10'h000;
  // ==========================================
  // dynamic crc-8 (designated 0xa6, normal form 0x4d)
  localparam logic [7:0] CRC8_POLY = 8'h4d;
  localparam int DYN_WORDS = 32;
  localparam logic [3:0] DYN_ADDR_LIMIT = 4'hf;
  // ==========================================
  // static checker states
  typedef enum logic [1:0] {
    ST_INIT = 2'b00,
    ST_RUN = 2'b01,
    ST_CHECK = 2'b10
  } rmp_scan_state_type;
endpackage : rmp_pkg

// ==== tb/rmp_regfile_model.sv ====
// Purpose: register file stand-in that answers scan reads and applies writes
// Assumes: every register starts at zero, as after an nvm load of zeros
// Notes: flip_i corrupts one protected byte, only when a test asks for it
module rmp_regfile_model (
  input wire logic clk_sys_i,
  input wire logic wr_en_i,
  input wire logic [2:0] wr_page_i,
  input wire logic [7:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic [2:0] s_page_i,
  input wire logic [7:0] s_addr_i,
  input wire logic [2:0] d_page_i,
  input wire logic [7:0] d_addr_i,
  input wire logic flip_i,
  output logic [7:0] s_data_o,
  output logic [7:0] d_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem_reg [0:7][0:255];
  // ==========================================
  // storage, zero at start
  initial begin
    for (int p = 0; p < 8; p++) begin
      for (int a = 0; a < 256; a++) begin
        mem_reg[p][a] = 8'h00;
      end
    end
  end
  // write applied at the edge ending the strobe cycle; raw bits kept
  always @(posedge clk_sys_i) begin
    if (wr_en_i) begin
      mem_reg[wr_page_i][wr_addr_i] <= wr_data_i;
    end else if (flip_i) begin
      mem_reg[3'h4][8'h03] <= mem_reg[3'h4][8'h03] ^ 8'h01;
    end
  end
  // same-cycle scan reads
  assign s_data_o = mem_reg[s_page_i][s_addr_i];
  assign d_data_o = mem_reg[d_page_i][d_addr_i];
endmodule : rmp_regfile_model

// ==== tb/tb.sv ====
// Purpose: self-checking bench for the register map protection block
// Assumes: host accesses arrive already parsed, one per request pulse
// Notes: expected static checksum is computed here over an all-zero map
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, vld = 1'b0, wr = 1'b0, ser = 1'b0, sec = 1'b0;
  logic [6:0] dev = 7'h00;
  logic [2:0] pf = 3'h0;
  logic [7:0] ra = 8'h00, wd = 8'h00, sd, dd;
  logic is_wd = 1'b0, is_esm = 1'b0, is_rate = 1'b0, fmode = 1'b0, run = 1'b0;
  logic lck = 1'b0, stu = 1'b0, ld = 1'b0, clr = 1'b0, flip = 1'b0, sbu = 1'b1;
  logic [15:0] exp_crc = 16'h0000;
  logic done, hit, grant, wen, lock, flag, shut;
  logic [2:0] page, wpage, spage, dpage;
  logic [7:0] waddr, wdata, saddr, daddr;
  logic f, s;
  int err_count = 0, num_checks = 0;
  always #5 clk = ~clk;
  // ==========================================
  // design and register file
  rmp_register_map_protection rmp_register_map_protection_inst (.clk_sys_i(clk),
    .reset_i(rst), .acc_valid_i(vld), .acc_write_i(wr), .acc_is_serial_i(ser),
    .acc_on_secondary_i(sec), .acc_dev_addr_i(dev), .acc_page_field_i(pf),
    .acc_reg_addr_i(ra), .acc_wdata_i(wd), .acc_is_wd_cfg_i(is_wd),
    .acc_is_esm_cfg_i(is_esm), .acc_is_rate_sel_i(is_rate),
    .primary_bus_base_identifier_i(7'h26), .secondary_bus_identifier_i(7'h38),
    .secondary_bus_used_i(sbu), .functional_mode_i(fmode),
    .supervision_timer_running_i(run), .error_signal_monitor_running_i(run),
    .rate_choice_nvm_lock_i(lck), .startup_i(stu), .nvm_loaded_i(ld),
    .nvm_crc16_expected_i(exp_crc), .static_scan_data_i(sd), .dyn_scan_data_i(dd),
    .crc_flag_clear_i(clr), .acc_done_o(done), .acc_hit_o(hit),
    .acc_granted_o(grant), .acc_page_o(page), .reg_wr_en_o(wen),
    .reg_wr_page_o(wpage), .reg_wr_addr_o(waddr), .reg_wr_data_o(wdata),
    .static_scan_page_o(spage), .static_scan_addr_o(saddr),
    .dyn_scan_page_o(dpage), .dyn_scan_addr_o(daddr), .user_lock_status_o(lock),
    .reg_crc_error_flag_o(flag), .shutdown_request_o(shut));
  rmp_regfile_model rmp_regfile_model_inst (.clk_sys_i(clk), .wr_en_i(wen),
    .wr_page_i(wpage), .wr_addr_i(waddr), .wr_data_i(wdata), .s_page_i(spage),
    .s_addr_i(saddr), .d_page_i(dpage), .d_addr_i(daddr), .flip_i(flip),
    .s_data_o(sd), .d_data_o(dd));
  // ==========================================
  // helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s got %h want %h", $time, m, got, exp);
    end
  endtask : chk
  // one access: {write, serial, secondary}, address fields, data
  task automatic acc(input logic [2:0] md, input logic [6:0] d, input logic [2:0] p,
                     input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    {wr, ser, sec} <= md;
    vld <= 1'b1;
    dev <= d;
    pf <= p;
    ra <= a;
    wd <= v;
    @(posedge clk);
    vld <= 1'b0;
    #1;
    chk(16'(done), 16'h1, "done");
  endtask : acc
  task automatic watch(input int n);
    f = 1'b0;
    s = 1'b0;
    repeat (n) begin
      @(posedge clk);
      #1;
      if (flag === 1'b1) f = 1'b1;
      if (shut === 1'b1) s = 1'b1;
    end
  endtask : watch
  task automatic pulse_clear();
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
  endtask : pulse_clear
  function automatic logic [15:0] crc_zero_map();
    logic [15:0] c;
    c = 16'hffff;
    repeat (768 * 8) begin
      c = c[15] ? {c[14:0], 1'b0} ^ 16'h755b : {c[14:0], 1'b0};
    end
    return ~c;
  endfunction : crc_zero_map
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict
  // ==========================================
  // scenarios
  task automatic t_decode();
    for (int i = 0; i < 4; i++) begin
      acc(3'b000, {5'h09, 2'(i)}, 3'h0, 8'h10, 8'h00);
      chk({15'h0, hit}, 16'h1, "two-wire hit");
      chk(16'(page), 16'(i), "two-wire page");
    end
    acc(3'b001, 7'h38, 3'h0, 8'h10, 8'h00);
    chk(16'({hit, page}), 16'hc, "secondary page");
    acc(3'b000, 7'h38, 3'h0, 8'h10, 8'h00);
    chk(16'(hit), 16'h0, "secondary id on primary");
    sbu <= 1'b0;
    acc(3'b000, 7'h38, 3'h0, 8'h10, 8'h00);
    chk(16'({hit, page}), 16'hc, "page 4 on lone bus");
    acc(3'b001, 7'h38, 3'h0, 8'h10, 8'h00);
    chk(16'(hit), 16'h0, "secondary bus unused");
    sbu <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      acc(3'b010, 7'h00, 3'(i), 8'h10, 8'h00);
      chk(16'(hit), (i < 5) ? 16'h1 : 16'h0, "serial hit");
      if (i < 5) chk(16'(page), 16'(i), "serial page");
    end
    $display("test decode done");
  endtask : t_decode
  task automatic t_page1();
    fmode <= 1'b1;
    acc(3'b010, 7'h00, 3'h1, 8'h20, 8'h00);
    chk(16'(grant), 16'h0, "page1 read functional");
    acc(3'b110, 7'h00, 3'h1, 8'h20, 8'h00);
    chk(16'({grant, wen}), 16'h0, "page1 write functional");
    fmode <= 1'b0;
    acc(3'b010, 7'h00, 3'h1, 8'h20, 8'h00);
    chk(16'(grant), 16'h1, "page1 read outside");
    $display("test page1 done");
  endtask : t_page1
  task automatic t_lock();
    acc(3'b110, 7'h00, 3'h0, 8'ha1, 8'h00);
    #10 chk(16'(lock), 16'h1, "lock on");
    acc(3'b110, 7'h00, 3'h0, 8'h10, 8'h00);
    chk(16'({grant, wen}), 16'h0, "locked write");
    acc(3'b110, 7'h00, 3'h0, 8'h5a, 8'h00);
    chk(16'({grant, wen}), 16'h3, "int first");
    acc(3'b110, 7'h00, 3'h0, 8'h6c, 8'h00);
    chk(16'(grant), 16'h1, "int last");
    acc(3'b110, 7'h00, 3'h0, 8'h59, 8'h00);
    chk(16'(grant), 16'h0, "below int");
    acc(3'b110, 7'h00, 3'h0, 8'h6d, 8'h00);
    chk(16'(grant), 16'h0, "above int");
    acc(3'b110, 7'h00, 3'h0, 8'ha1, 8'h9b);
    #10 chk(16'(lock), 16'h0, "unlock key");
    acc(3'b110, 7'h00, 3'h0, 8'h10, 8'h00);
    chk(16'(grant), 16'h1, "unlocked write");
    acc(3'b110, 7'h00, 3'h0, 8'ha1, 8'h9a);
    @(posedge clk);
    stu <= 1'b1;
    @(posedge clk);
    stu <= 1'b0;
    #1 chk(16'(lock), 16'h0, "start-up unlocks");
    $display("test lock done");
  endtask : t_lock
  task automatic t_cfg();
    for (int k = 0; k < 3; k++) begin
      for (int j = 0; j < 2; j++) begin
        is_wd <= (k == 0);
        is_esm <= (k == 1);
        is_rate <= (k == 2);
        run <= j[0];
        lck <= j[0];
        acc(3'b110, 7'h00, 3'h0, 8'h10, 8'h00);
        chk(16'(grant), j ? 16'h0 : 16'h1, "config write");
      end
    end
    {is_wd, is_esm, is_rate, run, lck} <= 5'h00;
    $display("test config done");
  endtask : t_cfg
  task automatic t_dyn();
    acc(3'b101, 7'h38, 3'h0, 8'h03, 8'h5a);
    chk(16'({wen, wpage, waddr}), 16'hc03, "page4 write");
    chk(16'(wdata), 16'h5a, "page4 data");
    watch(40);
    chk(16'(f), 16'h0, "clean round");
    @(posedge clk);
    flip <= 1'b1;
    @(posedge clk);
    flip <= 1'b0;
    watch(40);
    chk(16'({f, s}), 16'h3, "dynamic mismatch");
    acc(3'b101, 7'h38, 3'h0, 8'h03, 8'h5a);
    // let a check of the stale byte land before the clear
    @(posedge clk);
    pulse_clear();
    watch(40);
    chk(16'(f), 16'h0, "rewrite heals");
    $display("test dynamic done");
  endtask : t_dyn
  task automatic t_static();
    watch(800);
    chk(16'(f), 16'h0, "static good");
    acc(3'b110, 7'h00, 3'h1, 8'h20, 8'h80);
    watch(1600);
    chk(16'({f, s}), 16'h3, "reserved one");
    acc(3'b110, 7'h00, 3'h1, 8'h20, 8'h00);
    watch(800);
    pulse_clear();
    watch(800);
    chk(16'(f), 16'h0, "static restored");
    $display("test static done");
  endtask : t_static
  // ==========================================
  // main sequence and watchdog
  initial begin
    exp_crc = crc_zero_map();
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    ld <= 1'b1;
    #1 chk(16'({lock, flag, shut, spage}), 16'h1, "reset values");
    t_decode();
    t_page1();
    t_lock();
    t_cfg();
    t_dyn();
    t_static();
    print_verdict();
  end
  initial begin
    #100us;
    err_count++;
    $display("BAD %0t watchdog expired", $time);
    print_verdict();
  end
endmodule : tb
